/* design/snd_cmd_decoder.sv */
// Purpose : SPI NAND instruction decoder for a two-die stack
// Assumes : Pins sampled on clk, serial clock below clk / 8
// Notes   : Array, ECC and register contents live outside
//
// Behaviour
// - Configuration bit buf_mode set selects the buffer read frame formats
// - 03h/0Bh/3Bh/6Bh: two column bytes, one dummy, data on 1/1/2/4 lines
// - 0Ch/3Ch/6Ch: two column bytes, three dummy bytes, then data
// - BBh: address, one dummy and data on two lines; BCh three dummies
// - EBh: address, two dummies and data on four lines; ECh five
// - Two-line address: line 0 even column bits, line 1 odd bits
// - Two-line data: line 1 odd bits, line 0 even bits, MSB first
// - Four-line address: line n carries column bits n+12, n+8, n+4, n
// - Four-line data: line n carries bit n+4 then bit n
// - Only the low twelve column bits are used
// - Page address: upper ten bits block, lower six bits page
// - Block addresses: bits 9..0 block, logical bits 15..14 extra info
// - Register address Axh protection, Bxh configuration, Cxh status
// - Write-protect enable rejects all quad load and quad read opcodes
// - Continuous mode: read end gives 5 us busy and invalid buffer
// - Buffer mode: ready at once after a read, buffer kept
// - 02h/32h reset the buffer before loading; 84h/34h do not
// - One active die at a time, die 0 after power-up
// - C2h plus one identifier byte makes that die active
// - A busy die keeps working while another die is selected
// - Invalid identifier idles both dies until a valid select
// - Frame starts at chip select fall, opcode MSB first on rises
// - Write type frames not ending on a byte boundary are ignored
// - While busy only status reads, identification reads and die select are accepted
`timescale 1ns/10ps
`default_nettype none
`include "snd_params.svh"
module snd_cmd_decoder
  import snd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // SPI pins
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sclk,
  input  wire logic [3:0]  spi_io_in,
  output logic [3:0]       spi_io_out,
  output logic [3:0]       spi_io_oe_n,
  // Configuration
  input  wire logic        buf_mode,
  input  wire logic        wp_enable,
  // Dies
  input  wire logic [1:0]  die_busy,
  output logic [1:0]       die_active,
  // Status registers
  output logic [1:0]       sr_sel,
  input  wire logic [7:0]  sr_rdata,
  // Buffer read
  output logic             rd_req,
  output logic [11:0]      rd_column,
  input  wire logic [7:0]  rd_data,
  output logic             buf_invalid,
  output logic             cont_busy,
  // Program load
  output logic             load_stb,
  output logic [11:0]      load_column,
  output logic [7:0]       load_data,
  output logic             buf_reset,
  output logic             load_abort,
  // Committed commands
  output logic             cmd_stb,
  output logic [7:0]       cmd_opcode,
  output logic [31:0]      cmd_arg,
  output logic [15:0]      page_address,
  output logic [9:0]       page_block,
  output logic [5:0]       page_in_block,
  output logic [9:0]       logical_block_address,
  output logic [1:0]       logical_block_info,
  output logic [9:0]       physical_block_address
);
  import snd_pkg::*;

  // ==========================================================
  // Frame layout per opcode
  function automatic snd_cmd_s decode(input logic [7:0] op,
                                      input logic       bm);
    snd_cmd_s c;
    c        = '0;
    c.kind   = SND_K_BAD;
    c.alanes = `SND_L1;
    c.dlanes = `SND_L1;
    case (op)
      `SND_OP_RESET, `SND_OP_WR_EN, `SND_OP_WR_DIS, `SND_OP_WR_SR_A,
      `SND_OP_WR_SR_B, `SND_OP_SWAP, `SND_OP_ERASE, `SND_OP_PROG_EXEC,
      `SND_OP_PAGE_RD, `SND_OP_DIE_SEL:
        c.kind = SND_K_WRITE;
      `SND_OP_ID:
      begin
        c.kind = SND_K_ID;
        c.ndum = `SND_BUF_DUM_STD;
      end
      `SND_OP_RD_SR_A, `SND_OP_RD_SR_B:
      begin
        c.kind  = SND_K_SR;
        c.nargs = 3'd1;
      end
      `SND_OP_LOAD, `SND_OP_LOAD_RND, `SND_OP_LOAD_Q, `SND_OP_LOAD_Q_RND:
      begin
        c.kind    = SND_K_LOAD;
        c.nargs   = `SND_COL_BYTES;
        c.rst_buf = (op == `SND_OP_LOAD) || (op == `SND_OP_LOAD_Q);
      end
      `SND_OP_READ:
        c.ndum = bm ? `SND_BUF_DUM_STD : `SND_CONT_DUM_RD;
      `SND_OP_FAST, `SND_OP_DUAL, `SND_OP_QUAD, `SND_OP_DIO:
        c.ndum = bm ? `SND_BUF_DUM_STD : `SND_CONT_DUM_FST;
      `SND_OP_FAST4, `SND_OP_DUAL4, `SND_OP_QUAD4, `SND_OP_DIO4:
        c.ndum = bm ? `SND_BUF_DUM_4B : `SND_CONT_DUM_FST4;
      `SND_OP_QIO:
        c.ndum = bm ? `SND_BUF_DUM_QIO : `SND_CONT_DUM_QIO;
      `SND_OP_QIO4:
        c.ndum = bm ? `SND_BUF_DUM_QIO4 : `SND_CONT_DUM_QIO4;
      default:
        c.kind = SND_K_BAD;
    endcase
    case (op)
      `SND_OP_READ, `SND_OP_FAST, `SND_OP_FAST4, `SND_OP_DUAL,
      `SND_OP_DUAL4, `SND_OP_QUAD, `SND_OP_QUAD4, `SND_OP_DIO,
      `SND_OP_DIO4, `SND_OP_QIO, `SND_OP_QIO4:
      begin
        c.kind  = SND_K_READ;
        c.nargs = bm ? `SND_COL_BYTES : 3'd0;
      end
      default:
        c.nargs = c.nargs;
    endcase
    case (op)
      `SND_OP_DUAL, `SND_OP_DUAL4:
        c.dlanes = `SND_L2;
      `SND_OP_DIO, `SND_OP_DIO4:
      begin
        c.alanes = `SND_L2;
        c.dlanes = `SND_L2;
      end
      `SND_OP_QUAD, `SND_OP_QUAD4, `SND_OP_LOAD_Q, `SND_OP_LOAD_Q_RND:
      begin
        c.dlanes = `SND_L4;
        c.quad   = 1'b1;
      end
      `SND_OP_QIO, `SND_OP_QIO4:
      begin
        c.alanes = `SND_L4;
        c.dlanes = `SND_L4;
        c.quad   = 1'b1;
      end
      default:
        c.quad = 1'b0;
    endcase
    return c;
  endfunction

  // ==========================================================
  // Pins and output shifter
  snd_link_if lk ();

  snd_pin_sync u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .cs_n_pin (spi_cs_n),
    .sclk_pin (spi_sclk),
    .io_pin   (spi_io_in),
    .lk       (lk)
  );

  snd_tx_shift u_tx (
    .clk   (clk),
    .rst_n (rst_n),
    .lk    (lk)
  );

  // ==========================================================
  // Frame engine
  snd_core_s  q_ff;
  snd_core_s  nxt_q;
  snd_cmd_s   cmd;
  snd_lanes_t lanes;
  logic [7:0] shifted;
  logic [3:0] bits_sum;
  logic       byte_done;
  logic       busy_eff;
  logic       args_end;
  logic       to_data;

  always_comb
  begin
    nxt_q          = q_ff;
    nxt_q.cmd_stb  = 1'b0;
    nxt_q.ld_stb   = 1'b0;
    nxt_q.buf_rst  = 1'b0;
    nxt_q.ld_abort = 1'b0;
    nxt_q.fetch    = 1'b0;
    args_end       = 1'b0;
    to_data        = 1'b0;
    cmd = decode((q_ff.ph == SND_PH_OP) ? q_ff.sh : q_ff.op, buf_mode);
    case (q_ff.ph)
      SND_PH_ARG, SND_PH_DUMMY: lanes = cmd.alanes;
      SND_PH_DIN:               lanes = cmd.dlanes;
      default:                  lanes = `SND_L1;
    endcase
    case (lanes)
      `SND_L2: shifted = {q_ff.sh[5:0], lk.io_in[1:0]};
      `SND_L4: shifted = {q_ff.sh[3:0], lk.io_in};
      default: shifted = {q_ff.sh[6:0], lk.io_in[0]};
    endcase
    cmd       = decode((q_ff.ph == SND_PH_OP) ? shifted : q_ff.op, buf_mode);
    bits_sum  = q_ff.bits + {1'b0, lanes};
    byte_done = (bits_sum == `SND_BYTE_BITS);
    busy_eff  = die_busy[q_ff.die] | (q_ff.cbusy != 10'd0);
    if (q_ff.cbusy != 10'd0)
      nxt_q.cbusy = q_ff.cbusy - 10'd1;

    if (lk.cs_rise)
    begin
      nxt_q.ph = SND_PH_IDLE;
      if (q_ff.ph == SND_PH_ARG && cmd.kind == SND_K_WRITE
          && q_ff.bits == 4'd0)
      begin
        nxt_q.cmd_stb = 1'b1;
        if (q_ff.op == `SND_OP_PAGE_RD)
          nxt_q.binv = 1'b0;
        if (q_ff.op == `SND_OP_DIE_SEL)
        begin
          nxt_q.idle = !(q_ff.arg[7:0] == `SND_DIE0
                         || q_ff.arg[7:0] == `SND_DIE1);
          if (q_ff.arg[7:0] == `SND_DIE1)
            nxt_q.die = 1'b1;
          else if (q_ff.arg[7:0] == `SND_DIE0)
            nxt_q.die = 1'b0;
        end
      end
      if (cmd.kind == SND_K_LOAD && q_ff.bits != 4'd0
          && (q_ff.ph == SND_PH_ARG || q_ff.ph == SND_PH_DIN))
        nxt_q.ld_abort = 1'b1;
      if (cmd.kind == SND_K_READ && !buf_mode
          && (q_ff.ph == SND_PH_ARG || q_ff.ph == SND_PH_DUMMY
              || q_ff.ph == SND_PH_DOUT))
      begin
        nxt_q.cbusy = 10'(`SND_CONT_BUSY_CYC);
        nxt_q.binv  = 1'b1;
      end
    end
    else if (lk.cs_fall)
    begin
      nxt_q.ph   = SND_PH_OP;
      nxt_q.bits = 4'd0;
    end
    else if (lk.sclk_rise && (q_ff.ph == SND_PH_OP
             || q_ff.ph == SND_PH_ARG || q_ff.ph == SND_PH_DUMMY
             || q_ff.ph == SND_PH_DIN))
    begin
      nxt_q.sh   = shifted;
      nxt_q.bits = byte_done ? 4'd0 : bits_sum;
      if (byte_done)
      begin
        case (q_ff.ph)
          SND_PH_OP:
          begin
            nxt_q.op    = shifted;
            nxt_q.arg   = 32'h0;
            nxt_q.nbyte = cmd.nargs;
            if (cmd.kind == SND_K_BAD)
              nxt_q.ph = SND_PH_SKIP;
            else if (q_ff.idle && shifted != `SND_OP_DIE_SEL)
              nxt_q.ph = SND_PH_SKIP;
            else if (busy_eff && shifted != `SND_OP_DIE_SEL
                     && cmd.kind != SND_K_ID && cmd.kind != SND_K_SR)
              nxt_q.ph = SND_PH_SKIP;
            else if (wp_enable && cmd.quad)
              nxt_q.ph = SND_PH_SKIP;
            else if (cmd.kind == SND_K_WRITE || cmd.nargs != 3'd0)
              nxt_q.ph = SND_PH_ARG;
            else
              args_end = 1'b1;
          end
          SND_PH_ARG:
          begin
            nxt_q.arg = {q_ff.arg[23:0], shifted};
            if (cmd.kind != SND_K_WRITE)
            begin
              nxt_q.nbyte = q_ff.nbyte - 3'd1;
              args_end    = (q_ff.nbyte == 3'd1);
            end
          end
          SND_PH_DUMMY:
          begin
            nxt_q.nbyte = q_ff.nbyte - 3'd1;
            to_data     = (q_ff.nbyte == 3'd1);
          end
          default:
          begin
            nxt_q.ld_stb  = 1'b1;
            nxt_q.ld_data = shifted;
            nxt_q.ld_col  = q_ff.col;
            nxt_q.col     = q_ff.col + 12'd1;
          end
        endcase
      end
    end
    else if (q_ff.ph == SND_PH_DOUT && lk.tx_take)
    begin
      // Read ahead so a byte waits before the shifter needs it
      nxt_q.fetch = 1'b1;
      nxt_q.col   = q_ff.col + 12'd1;
      if (q_ff.idx != 2'd3)
        nxt_q.idx = q_ff.idx + 2'd1;
    end

    if (args_end)
    begin
      if (cmd.ndum != 3'd0)
      begin
        nxt_q.ph    = SND_PH_DUMMY;
        nxt_q.nbyte = cmd.ndum;
      end
      else
        to_data = 1'b1;
    end
    if (to_data)
    begin
      nxt_q.col = nxt_q.arg[11:0];
      nxt_q.idx = 2'd0;
      if (cmd.kind == SND_K_LOAD)
      begin
        nxt_q.ph      = SND_PH_DIN;
        nxt_q.buf_rst = cmd.rst_buf;
      end
      else
      begin
        nxt_q.ph    = SND_PH_DOUT;
        nxt_q.fetch = 1'b1;
      end
    end

    if (q_ff.fetch)
    begin
      case (cmd.kind)
        SND_K_ID:
          case (q_ff.idx)
            2'd0:    nxt_q.tx_byte = `SND_MFR_ID;
            2'd1:    nxt_q.tx_byte = `SND_DEV_ID_HI;
            2'd2:    nxt_q.tx_byte = `SND_DEV_ID_LO;
            default: nxt_q.tx_byte = 8'h00;
          endcase
        SND_K_SR: nxt_q.tx_byte = sr_rdata;
        default:  nxt_q.tx_byte = rd_data;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q_ff <= '0;
    else
      q_ff <= nxt_q;
  end

  // ==========================================================
  // Outputs
  assign lk.tx_en    = (q_ff.ph == SND_PH_DOUT);
  assign lk.tx_lanes = cmd.dlanes;
  assign lk.tx_byte  = q_ff.tx_byte;
  assign spi_io_out  = lk.io_out;
  assign spi_io_oe_n = lk.io_oe_n;

  // Invalid identifier leaves no die answering
  assign die_active = q_ff.idle ? 2'b00 : (q_ff.die ? 2'b10 : 2'b01);

  always_comb
  begin
    // Read uses the first argument byte, write the one before data
    case ((cmd.kind == SND_K_SR) ? q_ff.arg[7:4] : q_ff.arg[15:12])
      `SND_SR_PROT: sr_sel = `SND_SEL_PROT;
      `SND_SR_CONF: sr_sel = `SND_SEL_CONF;
      `SND_SR_STAT: sr_sel = `SND_SEL_STAT;
      default:      sr_sel = `SND_SEL_NONE;
    endcase
  end

  assign rd_req      = q_ff.fetch && (cmd.kind == SND_K_READ);
  assign rd_column   = q_ff.col;
  assign buf_invalid = q_ff.binv;
  assign cont_busy   = (q_ff.cbusy != 10'd0);
  assign load_stb    = q_ff.ld_stb;
  assign load_column = q_ff.ld_col;
  assign load_data   = q_ff.ld_data;
  assign buf_reset   = q_ff.buf_rst;
  assign load_abort  = q_ff.ld_abort;
  assign cmd_stb     = q_ff.cmd_stb;
  assign cmd_opcode  = q_ff.op;
  assign cmd_arg     = q_ff.arg;
  assign page_address           = q_ff.arg[15:0];
  assign page_block             = q_ff.arg[15:6];
  assign page_in_block          = q_ff.arg[5:0];
  assign logical_block_address  = q_ff.arg[25:16];
  assign logical_block_info     = q_ff.arg[31:30];
  assign physical_block_address = q_ff.arg[9:0];

endmodule // snd_cmd_decoder
`default_nettype wire

/* common/snd_params.svh */
// Purpose : Constants of the SPI NAND instruction decoder
// Assumes : Included by the decoder package users
// Notes   : Macros only, no logic
`ifndef SND_PARAMS_SVH
`define SND_PARAMS_SVH

// ==========================================================
// Opcodes
`define SND_OP_RESET      8'hff
`define SND_OP_DIE_SEL    8'hc2
`define SND_OP_ID         8'h9f
`define SND_OP_RD_SR_A    8'h0f
`define SND_OP_RD_SR_B    8'h05
`define SND_OP_WR_SR_A    8'h1f
`define SND_OP_WR_SR_B    8'h01
`define SND_OP_WR_EN      8'h06
`define SND_OP_WR_DIS     8'h04
`define SND_OP_SWAP       8'ha1
`define SND_OP_ERASE      8'hd8
`define SND_OP_PROG_EXEC  8'h10
`define SND_OP_PAGE_RD    8'h13
`define SND_OP_LOAD       8'h02
`define SND_OP_LOAD_RND   8'h84
`define SND_OP_LOAD_Q     8'h32
`define SND_OP_LOAD_Q_RND 8'h34
`define SND_OP_READ       8'h03
`define SND_OP_FAST       8'h0b
`define SND_OP_FAST4      8'h0c
`define SND_OP_DUAL       8'h3b
`define SND_OP_DUAL4      8'h3c
`define SND_OP_QUAD       8'h6b
`define SND_OP_QUAD4      8'h6c
`define SND_OP_DIO        8'hbb
`define SND_OP_DIO4       8'hbc
`define SND_OP_QIO        8'heb
`define SND_OP_QIO4       8'hec

// ==========================================================
// Frame fields
`define SND_COL_BYTES     3'd2
`define SND_BUF_DUM_STD   3'd1
`define SND_BUF_DUM_4B    3'd3
`define SND_BUF_DUM_QIO   3'd2
`define SND_BUF_DUM_QIO4  3'd5
`define SND_CONT_DUM_RD   3'd3
`define SND_CONT_DUM_FST  3'd4
`define SND_CONT_DUM_FST4 3'd5
`define SND_CONT_DUM_QIO  3'd6
`define SND_CONT_DUM_QIO4 3'd7
`define SND_L1            3'd1
`define SND_L2            3'd2
`define SND_L4            3'd4
`define SND_BYTE_BITS     4'd8
`define SND_SR_PROT       4'ha
`define SND_SR_CONF       4'hb
`define SND_SR_STAT       4'hc
`define SND_SEL_PROT      2'd0
`define SND_SEL_CONF      2'd1
`define SND_SEL_STAT      2'd2
`define SND_SEL_NONE      2'd3
`define SND_DIE0          8'h00
`define SND_DIE1          8'h01
`define SND_SYNC_RST      6'h20
// Identity bytes, values arbitrary
`define SND_MFR_ID        8'h5a
`define SND_DEV_ID_HI     8'h3c
`define SND_DEV_ID_LO     8'h96

// ==========================================================
// Timing
`define SND_CLK_PERIOD_NS 10
`define SND_CONT_BUSY_NS  5000
`define SND_CONT_BUSY_CYC (`SND_CONT_BUSY_NS / `SND_CLK_PERIOD_NS)

`endif

/* common/snd_pkg.sv */
// Purpose : Types of the SPI NAND instruction decoder
// Assumes : Nothing
// Notes   : State structs of all three modules
package snd_pkg;

  // ========================================================
  // Enumerations
  typedef logic [2:0] snd_lanes_t;

  typedef enum logic [2:0] {
    SND_PH_IDLE  = 3'b000,
    SND_PH_OP    = 3'b001,
    SND_PH_ARG   = 3'b010,
    SND_PH_DUMMY = 3'b011,
    SND_PH_DOUT  = 3'b100,
    SND_PH_DIN   = 3'b101,
    SND_PH_SKIP  = 3'b110
  } snd_phase_e;

  typedef enum logic [2:0] {
    SND_K_BAD   = 3'b000,
    SND_K_WRITE = 3'b001,
    SND_K_READ  = 3'b010,
    SND_K_ID    = 3'b011,
    SND_K_SR    = 3'b100,
    SND_K_LOAD  = 3'b101
  } snd_kind_e;

  // ========================================================
  // Structs
  typedef struct packed {
    snd_kind_e  kind;
    logic [2:0] nargs;
    logic [2:0] ndum;
    snd_lanes_t alanes;
    snd_lanes_t dlanes;
    logic       quad;
    logic       rst_buf;
  } snd_cmd_s;

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
  } snd_sync_s;

  typedef struct packed {
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [3:0] out;
    logic [3:0] oe_n;
    logic       take;
  } snd_tx_s;

  typedef struct packed {
    snd_phase_e ph;
    logic [7:0]  op;
    logic [7:0]  sh;
    logic [3:0]  bits;
    logic [2:0]  nbyte;
    logic [31:0] arg;
    logic [11:0] col;
    logic [1:0]  idx;
    logic        fetch;
    logic [7:0]  tx_byte;
    logic        cmd_stb;
    logic        ld_stb;
    logic [7:0]  ld_data;
    logic [11:0] ld_col;
    logic        buf_rst;
    logic        ld_abort;
    logic        die;
    logic        idle;
    logic [9:0]  cbusy;
    logic        binv;
  } snd_core_s;

endpackage

/* common/snd_link_if.sv */
// Purpose : Carries sampled pins and the output shifter handshake
// Assumes : All signals on clk
// Notes   : Pulses last one clk cycle
`timescale 1ns/10ps
`default_nettype none
interface snd_link_if;
  import snd_pkg::*;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_fall;
  logic       cs_rise;
  logic [3:0] io_in;
  logic       tx_en;
  snd_lanes_t tx_lanes;
  logic [7:0] tx_byte;
  logic       tx_take;
  logic [3:0] io_out;
  logic [3:0] io_oe_n;

  modport sync (output sclk_rise, sclk_fall, cs_fall, cs_rise, io_in);
  modport core (input sclk_rise, cs_fall, cs_rise, io_in, tx_take,
                io_out, io_oe_n,
                output tx_en, tx_lanes, tx_byte);
  modport shifter (input sclk_fall, tx_en, tx_lanes, tx_byte,
                   output tx_take, io_out, io_oe_n);
endinterface
`default_nettype wire

/* design/snd_pin_sync.sv */
// Purpose : Two-stage sampling of the SPI pins and edge finding
// Assumes : Serial clock far slower than clk
// Notes   : Edges come from the second and third stages
`timescale 1ns/10ps
`default_nettype none
`include "snd_params.svh"
module snd_pin_sync
(
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // Raw pins
  input  wire logic  cs_n_pin,
  input  wire logic  sclk_pin,
  input  wire logic [3:0] io_pin,
  // Sampled side
  snd_link_if.sync   lk
);
  import snd_pkg::*;

  // ========================================================
  // State
  snd_sync_s q_ff;
  snd_sync_s nxt_q;

  always_comb
  begin
    nxt_q    = q_ff;
    nxt_q.s1 = {cs_n_pin, sclk_pin, io_pin};
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q_ff <= '{s1: `SND_SYNC_RST, s2: `SND_SYNC_RST, s3: `SND_SYNC_RST};
    else
      q_ff <= nxt_q;
  end

  // ========================================================
  // Edges, stage one stays private to stage two
  assign lk.sclk_rise = q_ff.s2[4] & ~q_ff.s3[4];
  assign lk.sclk_fall = ~q_ff.s2[4] & q_ff.s3[4];
  assign lk.cs_fall   = ~q_ff.s2[5] & q_ff.s3[5];
  assign lk.cs_rise   = q_ff.s2[5] & ~q_ff.s3[5];
  assign lk.io_in     = q_ff.s2[3:0];

endmodule // snd_pin_sync
`default_nettype wire

/* design/snd_tx_shift.sv */
// Purpose : Output shifter on the falling serial clock edge
// Assumes : Next byte is waiting in tx_byte before a byte ends
// Notes   : Output enables are active low
`timescale 1ns/10ps
`default_nettype none
`include "snd_params.svh"
module snd_tx_shift
(
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Link
  snd_link_if.shifter lk
);
  import snd_pkg::*;

  // ========================================================
  // State
  snd_tx_s    q_ff;
  snd_tx_s    nxt_q;
  logic [7:0] src;
  logic [3:0] rem;

  always_comb
  begin
    nxt_q      = q_ff;
    nxt_q.take = 1'b0;
    src        = (q_ff.cnt == 4'd0) ? lk.tx_byte : q_ff.sh;
    rem        = (q_ff.cnt == 4'd0) ? `SND_BYTE_BITS : q_ff.cnt;
    if (!lk.tx_en)
    begin
      nxt_q.cnt  = 4'd0;
      nxt_q.oe_n = 4'hf;
    end
    else if (lk.sclk_fall)
    begin
      nxt_q.take = (q_ff.cnt == 4'd0);
      nxt_q.cnt  = rem - {1'b0, lk.tx_lanes};
      case (lk.tx_lanes)
        `SND_L2:
        begin
          nxt_q.out  = {2'b00, src[7:6]};
          nxt_q.oe_n = 4'b1100;
          nxt_q.sh   = {src[5:0], 2'b00};
        end
        `SND_L4:
        begin
          nxt_q.out  = src[7:4];
          nxt_q.oe_n = 4'b0000;
          nxt_q.sh   = {src[3:0], 4'h0};
        end
        default:
        begin
          // Single lane data leaves on line 1
          nxt_q.out  = {2'b00, src[7], 1'b0};
          nxt_q.oe_n = 4'b1101;
          nxt_q.sh   = {src[6:0], 1'b0};
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q_ff <= '{sh: 8'h00, cnt: 4'h0, out: 4'h0, oe_n: 4'hf, take: 1'b0};
    else
      q_ff <= nxt_q;
  end

  assign lk.tx_take = q_ff.take;
  assign lk.io_out  = q_ff.out;
  assign lk.io_oe_n = q_ff.oe_n;

endmodule // snd_tx_shift
`default_nettype wire

/* test/snd_host_model.sv */
// Purpose: SPI host model driving the decoder pins
// Assumes: Mode 0, serial clock of 16 clk cycles
// Notes  : Reads sampled on each rise into rx
`timescale 1ns/10ps
`default_nettype none
module snd_host_model (
  // System clock
  input  wire logic       clk,
  // SPI side
  input  wire logic [3:0] dout,
  output logic            cs_n,
  output logic            sclk,
  output logic [3:0]      io
);
  logic [31:0] rx;
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io = 4'h0;
  end
  // ==========
  // Frame control
  task automatic start();
    @(negedge clk) cs_n = 1'b0;
  endtask
  // Lanes MSB first
  task automatic shift(input logic [31:0] v, input int n, input int l);
    for (int i = n - l; i >= 0; i -= l)
    begin
      repeat (8) @(negedge clk);
      sclk = 1'b0;
      io = 4'((v >> i) & ((1 << l) - 1));
      repeat (8) @(negedge clk);
      sclk = 1'b1;
      rx = (rx << l) | 32'(l == 1 ? {3'h0, dout[1]} : dout);
    end
  endtask
  task automatic stop();
    repeat (8) @(negedge clk);
    sclk = 1'b0;
    repeat (8) @(negedge clk);
    cs_n = 1'b1;
    repeat (24) @(negedge clk);
  endtask
endmodule // snd_host_model
`default_nettype wire

/* test/snd_cmd_decoder_monitor.sv */
// Purpose: Port checker of snd_cmd_decoder
// Assumes: Busy after continuous read lasts 500 clk
// Notes  : Bound to every decoder instance
`timescale 1ns/10ps
`default_nettype none
module snd_cmd_decoder_monitor (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       spi_cs_n,
  input wire logic [3:0] spi_io_oe_n,
  input wire logic       buf_mode,
  input wire logic [1:0] die_active,
  input wire logic       rd_req,
  input wire logic       cont_busy,
  input wire logic       buf_invalid,
  input wire logic       cmd_stb
);
  logic [9:0] bcnt_ff;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      bcnt_ff <= 10'h000;
    else
      bcnt_ff <= cont_busy ? bcnt_ff + 10'h001 : 10'h000;
  // ==========
  // Assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_one_die: assert property ($onehot0(die_active))
    else $error("two dies active");
  chk_idle_oe: assert property (spi_cs_n [*8] |-> spi_io_oe_n == 4'hf)
    else $error("drive outside frame");
  chk_busy_len: assert property ($fell(cont_busy) |-> bcnt_ff == 10'h1f4)
    else $error("busy length");
  chk_busy_inv: assert property ($rose(cont_busy) |-> ##[0:2] buf_invalid)
    else $error("buffer not invalid");
  chk_buf_ready: assert property ($rose(cont_busy) |-> !$past(buf_mode))
    else $error("busy in buffer mode");
  chk_rd_pulse: assert property (rd_req |=> !rd_req)
    else $error("read request too long");
  chk_stb_end: assert property (cmd_stb |-> spi_cs_n && $past(spi_cs_n, 2))
    else $error("commit inside frame");
  chk_die_commit: assert property ($changed(die_active) |-> cmd_stb)
    else $error("die change without commit");
  cover property ($rose(cont_busy));
  cover property (cmd_stb);
  cover property (rd_req);
endmodule // snd_cmd_decoder_monitor
bind snd_cmd_decoder snd_cmd_decoder_monitor u_mon (.clk, .rst_n,
  .spi_cs_n, .spi_io_oe_n, .buf_mode, .die_active, .rd_req, .cont_busy,
  .buf_invalid, .cmd_stb);
`default_nettype wire

/* test/testbench.sv */
// Purpose: Self-checking bench of snd_cmd_decoder
// Assumes: Host model drives the pins
// Notes  : Buffer byte is column low byte xor 5a
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk, rst_n, spi_cs_n, spi_sclk, buf_mode, wp_enable;
  logic [3:0]  spi_io_in, spi_io_out, spi_io_oe_n;
  logic [1:0]  die_active, die_busy = 2'b00;
  logic        rd_req, buf_invalid, cont_busy, cmd_stb;
  logic [11:0] rd_column, seen_col;
  logic [7:0]  rd_data;
  logic [9:0]  page_block;
  logic [5:0]  page_in_block;
  int          fails, check_count, nreq, nstb;
  logic [19:0] tab [11] = '{20'h03111, 20'h0b111, 20'h3b112, 20'h6b114,
    20'h0c131, 20'h3c132, 20'h6c134, 20'hbb212, 20'hbc232, 20'heb424,
    20'hec454};
  assign rd_data = rd_column[7:0] ^ 8'h5a;
  snd_cmd_decoder u_dut (.clk, .rst_n, .spi_cs_n, .spi_sclk, .spi_io_in,
    .spi_io_out, .spi_io_oe_n, .buf_mode, .wp_enable, .die_busy,
    .die_active, .sr_sel(), .sr_rdata(8'h00), .rd_req, .rd_column,
    .rd_data, .buf_invalid, .cont_busy, .load_stb(), .load_column(),
    .load_data(), .buf_reset(), .load_abort(), .cmd_stb, .cmd_opcode(),
    .cmd_arg(), .page_address(), .page_block, .page_in_block,
    .logical_block_address(), .logical_block_info(),
    .physical_block_address());
  snd_host_model u_host (.clk, .dout(spi_io_out), .cs_n(spi_cs_n),
    .sclk(spi_sclk), .io(spi_io_in));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (rd_req === 1'b1 && nreq == 0) seen_col = rd_column;
    if (rd_req === 1'b1) nreq++;
    if (cmd_stb === 1'b1) nstb++;
  end
  // ==========
  // Tasks
  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e)
    begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic stop_test();
    $display("fails %0d checks %0d", fails, check_count);
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic frame(input logic [31:0] v, input int n);
    u_host.start();
    u_host.shift(v, n, 1);
    u_host.stop();
  endtask
  task automatic rd(input logic [19:0] e, input logic [15:0] c);
    nreq = 0;
    u_host.start();
    u_host.shift(32'(e[19:12]), 8, 1);
    u_host.shift(32'(c), 16, int'(e[11:8]));
    u_host.shift(32'h0, 8 * int'(e[7:4]), int'(e[11:8]));
    u_host.shift(32'h5555aaaa, 8, int'(e[3:0]));
    u_host.stop();
  endtask
  task automatic t_reads();
    logic [15:0] c;
    foreach (tab[i])
    begin
      c = 16'hf8c0 + 16'(i);
      rd(tab[i], c);
      chk("col", seen_col, c[11:0]);
      chk("data", u_host.rx[7:0], c[7:0] ^ 8'h5a);
      chk("ready", cont_busy, 1'b0);
    end
    wp_enable = 1'b1;
    rd(tab[3], c);
    chk("wp", nreq, 0);
    wp_enable = 1'b0;
  endtask
  task automatic t_die();
    logic [7:0] id [3] = '{8'h01, 8'h05, 8'h00};
    logic [1:0] ex [3] = '{2'b10, 2'b00, 2'b01};
    int n0;
    foreach (id[i])
    begin
      frame({16'h0, 8'hc2, id[i]}, 16);
      chk("die", die_active, ex[i]);
    end
    n0 = nstb;
    frame(32'h30, 11);
    chk("part", nstb, n0);
    frame(32'h06, 8);
    chk("full", nstb, n0 + 1);
    die_busy = 2'b01;
    frame(32'h06, 8);
    chk("gate", nstb, n0 + 1);
    frame({16'h0, 8'hc2, 8'h01}, 16);
    chk("sel", die_active, 2'b10);
  endtask
  task automatic t_cont();
    buf_mode = 1'b0;
    frame(32'h03000000, 32);
    chk("busy", cont_busy, 1'b1);
    chk("inv", buf_invalid, 1'b1);
    for (int k = 0; k < 600 && cont_busy !== 1'b0; k++) @(negedge clk);
    if (cont_busy !== 1'b0)
    begin
      fails++;
      stop_test();
    end
    frame(32'h13001234, 32);
    chk("blk", page_block, 10'h048);
    chk("pg", page_in_block, 6'h34);
    chk("inv", buf_invalid, 1'b0);
  endtask
  initial
  begin
    buf_mode = 1'b1;
    wp_enable = 1'b0;
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("die0", die_active, 2'b01);
    t_reads();
    t_die();
    t_cont();
    stop_test();
  end
  initial
  begin
    #1000000;
    fails++;
    stop_test();
  end
endmodule // testbench
`default_nettype wire
